/* rtl/mpt_pkg.sv */
/*
  constants, field layout and register map of the six-channel pulse timer unit.
  assumes a single 250 MHz peripheral clock and a 32-bit AHB-Lite register bus.
*/
//Contract
//- buffered compare A copies register C into A
//- buffered capture A shifts old A into C
//- cascade: ch1 over ch2, ch4 over ch5
//- upper counts on lower overflow and underflow
//- lower underflow only in phase counting
//- upper in phase counting ignores cascade select
//- simultaneous captures latch both 16-bit halves
//- pwm match drives pin low, high, toggle
//- pwm duty reachable from 0% to 100%
//- pwm per channel, clearing register sets period
//- pwm mode 1 pairs A/B and C/D
//- pwm mode 1 starts at A/C initial level
//- mode 1 equal pair values keep level
//- mode 2 period clear restores initial levels
//- mode 2 duty equal to period keeps level
//- mode 2 period register pin gives no output
//- phase counting only on channels 1,2,4,5
//- phase counting ignores prescaler and edge fields
//- phase overflow and underflow set their flags
//- readable direction flag in status register
//- ch1/5 use inputs A/B, ch2/4 C/D
//- four phase counting sub-modes
//- counter wraps all ones to zero, flags
//- flags set, enabled flags request interrupt
package mpt_pkg;
  localparam int         NCH          = 6;
  localparam int         NGR          = 4;
  localparam int         DIV_W        = 6;
  // ------------------------------------------------------------
  // register map: byte address = channel * 0x40 + index * 4
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_MODE     = 4'h1;
  localparam logic [3:0] IDX_IO       = 4'h2;
  localparam logic [3:0] IDX_IER      = 4'h3;
  localparam logic [3:0] IDX_STAT     = 4'h4;
  localparam logic [3:0] IDX_CNT      = 4'h5;
  localparam logic [3:0] IDX_GRA      = 4'h6;
  localparam logic [3:0] IDX_GRB      = 4'h7;
  localparam logic [3:0] IDX_GRD      = 4'h9;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int         CTRL_W       = 9;
  localparam int         CTRL_RUN     = 0;
  localparam int         CTRL_PSC     = 1;
  localparam int         CTRL_EDGE    = 4;
  localparam int         CTRL_CLR     = 6;
  localparam int         MODE_W       = 7;
  localparam int         MODE_PWM     = 0;
  localparam int         MODE_PHASE   = 2;
  localparam int         MODE_SUB     = 3;
  localparam int         MODE_BUFA    = 5;
  localparam int         IO_INIT      = 2;
  localparam int         IO_CAP       = 3;
  localparam int         FLAG_W       = 6;
  // ------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] PSC_DIV4     = 3'h1;
  localparam logic [2:0] PSC_DIV16    = 3'h2;
  localparam logic [2:0] PSC_DIV64    = 3'h3;
  localparam logic [2:0] PSC_CASCADE  = 3'h7;
  localparam logic [2:0] CLR_NONE     = 3'h0;
  localparam logic [2:0] CLR_LAST     = 3'h4;
  localparam logic [1:0] PWM_M1       = 2'h1;
  localparam logic [1:0] PWM_M2       = 2'h2;
  localparam logic [1:0] ACT_HOLD     = 2'h0;
  localparam logic [1:0] ACT_LOW      = 2'h1;
  localparam logic [1:0] ACT_HIGH     = 2'h2;
  localparam logic [1:0] ACT_TOGGLE   = 2'h3;
  localparam logic [1:0] EDGE_RISE    = 2'h0;
  localparam logic [1:0] EDGE_FALL    = 2'h1;
  localparam logic [1:0] SUB_X4       = 2'h0;
  localparam logic [1:0] SUB_A_FALL   = 2'h1;
  localparam logic [1:0] SUB_A_BOTH   = 2'h2;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] GR_RST      = 16'hFFFF;
  localparam logic       DIR_RST      = 1'b1;
  // channel capability masks, bit n = channel n
  localparam logic [5:0] PHASE_CH     = 6'h36;
  localparam logic [5:0] CD_CH        = 6'h09;
  localparam logic [5:0] UPPER_CH     = 6'h12;
  localparam logic [5:0] SRC_CD       = 6'h14;
endpackage : mpt_pkg

/* rtl/mpt_quad.sv */
/*
  two-phase encoder decoder: synchronises one phase pair and produces
  one-cycle up and down count pulses per the selected sub-mode.
  assumes the phase inputs are asynchronous to hclk.
*/
`timescale 1ns/1ps
module mpt_quad
  import mpt_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       phase_a,
  input  wire logic       phase_b,
  input  wire logic [1:0] sub_mode,
  output logic            count_up,
  output logic            count_dn
);
  logic [2:0] a_q;
  logic [2:0] b_q;
  logic       a_r;
  logic       a_f;
  logic       b_r;
  logic       b_f;
  logic       up_d;
  logic       dn_d;

  // ------------------------------------------------------------
  // two-stage synchroniser plus edge reference stage
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_q <= 3'h0;
      b_q <= 3'h0;
    end
    else
    begin
      a_q <= {a_q[1:0], phase_a};
      b_q <= {b_q[1:0], phase_b};
    end
  end

  assign a_r = a_q[1] & ~a_q[2];
  assign a_f = ~a_q[1] & a_q[2];
  assign b_r = b_q[1] & ~b_q[2];
  assign b_f = ~b_q[1] & b_q[2];

  // ------------------------------------------------------------
  // sub-mode decode
  // ------------------------------------------------------------
  always_comb
  begin
    case (sub_mode)
      SUB_X4:
      begin
        up_d = (a_r & ~b_q[1]) | (a_f & b_q[1]) | (b_r & a_q[1]) | (b_f & ~a_q[1]);
        dn_d = (a_r & b_q[1]) | (a_f & ~b_q[1]) | (b_r & ~a_q[1]) | (b_f & a_q[1]);
      end
      SUB_A_FALL:
      begin
        up_d = a_f & ~b_q[1];
        dn_d = a_r & ~b_q[1];
      end
      SUB_A_BOTH:
      begin
        up_d = a_f & ~b_q[1];
        dn_d = a_f & b_q[1];
      end
      default:
      begin
        up_d = (b_r & a_q[1]) | (b_f & ~a_q[1]);
        dn_d = (b_f & a_q[1]) | (b_r & ~a_q[1]);
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_up <= 1'b0;
      count_dn <= 1'b0;
    end
    else
    begin
      count_up <= up_d;
      count_dn <= dn_d;
    end
  end
endmodule : mpt_quad

/* rtl/mpt_top.sv */
/*
  six-channel 16-bit pulse timer unit: counters, compare/capture,
  buffer transfer, cascading, pwm modes 1/2 and phase counting.
  assumes an AHB-Lite master with single word transfers on hclk;
  capture pins and encoder inputs are asynchronous.
*/
`timescale 1ns/1ps
module mpt_top
  import mpt_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic      [31:0]    hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire logic           ext_clock_in_a,
  input  wire logic           ext_clock_in_b,
  input  wire logic           ext_clock_in_c,
  input  wire logic           ext_clock_in_d,
  input  wire logic [NCH-1:0] capture_compare_pin_a_i,
  input  wire logic [NCH-1:0] capture_compare_pin_b_i,
  input  wire logic [NCH-1:0] capture_compare_pin_c_i,
  input  wire logic [NCH-1:0] capture_compare_pin_d_i,
  output logic      [NCH-1:0] capture_compare_pin_a_o,
  output logic      [NCH-1:0] capture_compare_pin_b_o,
  output logic      [NCH-1:0] capture_compare_pin_c_o,
  output logic      [NCH-1:0] capture_compare_pin_d_o,
  output logic      [NCH-1:0] capture_compare_pin_a_oe,
  output logic      [NCH-1:0] capture_compare_pin_b_oe,
  output logic      [NCH-1:0] capture_compare_pin_c_oe,
  output logic      [NCH-1:0] capture_compare_pin_d_oe,
  output logic      [NCH-1:0] irq_req
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q   [NCH];
  logic [MODE_W-1:0] mode_q   [NCH];
  logic [15:0]       io_q     [NCH];
  logic [FLAG_W-1:0] ier_q    [NCH];
  logic [FLAG_W-1:0] flag_q   [NCH];
  logic              dir_q    [NCH];
  logic [15:0]       cnt_q    [NCH];
  logic [15:0]       gr_q     [NCH][NGR];
  logic [NGR-1:0]    pin_q    [NCH];
  logic [NGR-1:0]    oe_q     [NCH];
  logic [DIV_W-1:0]  div_q;
  logic [NCH-1:0]    ovf_w;
  logic [NCH-1:0]    udf_w;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic              wr_pend_q;
  logic [2:0]        wr_ch_q;
  logic [3:0]        wr_idx_q;

  function automatic logic wr_hit(input logic [2:0] ch, input logic [3:0] idx);
    return wr_pend_q & (wr_ch_q == ch) & (wr_idx_q == idx);
  endfunction : wr_hit

  function automatic logic tick_of(input logic [2:0] psc, input logic [DIV_W-1:0] div);
    logic t;
    t = 1'b1;
    if (psc == PSC_DIV4)
      t = (div[1:0] == 2'h0);
    else if (psc == PSC_DIV16)
      t = (div[3:0] == 4'h0);
    else if (psc == PSC_DIV64)
      t = (div == 6'h00);
    return t;
  endfunction : tick_of

  function automatic logic apply_act(input logic lvl, input logic [1:0] act);
    logic r;
    r = lvl;
    if (act == ACT_LOW)
      r = 1'b0;
    else if (act == ACT_HIGH)
      r = 1'b1;
    else if (act == ACT_TOGGLE)
      r = ~lvl;
    return r;
  endfunction : apply_act

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  logic [2:0]  a_ch;
  logic [2:0]  a_chs;
  logic [3:0]  a_idx;
  logic [3:0]  gr_off;
  logic        a_hit;
  logic        take;
  logic [31:0] rd_d;

  assign a_ch   = haddr[8:6];
  assign a_idx  = haddr[5:2];
  assign a_hit  = (haddr[31:9] == 23'h000000) & (a_ch < 3'(NCH)) &
                  ((a_idx <= IDX_GRB) | ((a_idx <= IDX_GRD) & CD_CH[a_ch]));
  assign a_chs  = a_hit ? a_ch : 3'h0;
  assign take   = hsel & hready & htrans[1];
  assign gr_off = a_idx - IDX_GRA;

  always_comb
  begin
    rd_d = 32'h00000000;
    if (!a_hit)
      rd_d = 32'h00000000;
    else if (a_idx == IDX_CTRL)
      rd_d = {23'h000000, ctrl_q[a_chs]};
    else if (a_idx == IDX_MODE)
      rd_d = {25'h0000000, mode_q[a_chs]};
    else if (a_idx == IDX_IO)
      rd_d = {16'h0000, io_q[a_chs]};
    else if (a_idx == IDX_IER)
      rd_d = {26'h0000000, ier_q[a_chs]};
    else if (a_idx == IDX_STAT)
      rd_d = {25'h0000000, dir_q[a_chs], flag_q[a_chs]};
    else if (a_idx == IDX_CNT)
      rd_d = {16'h0000, cnt_q[a_chs]};
    else
      rd_d = {16'h0000, gr_q[a_chs][gr_off[1:0]]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ch_q   <= 3'h0;
      wr_idx_q  <= 4'h0;
      div_q     <= 6'h00;
    end
    else
    begin
      hrdata    <= (take & ~hwrite) ? rd_d : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= take & hwrite & a_hit;
      wr_ch_q   <= a_ch;
      wr_idx_q  <= a_idx;
      div_q     <= div_q + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    localparam logic [2:0] CI = 3'(c);
    logic [3:0]  pin_raw;
    logic [3:0]  s1_q;
    logic [3:0]  s2_q;
    logic [3:0]  s3_q;
    logic [3:0]  hit;
    logic [3:0]  capt;
    logic [3:0]  ev;
    logic        run;
    logic        ph;
    logic        casc;
    logic        inc;
    logic        dec;
    logic        clr;
    logic        per_ok;
    logic        q_up;
    logic        q_dn;
    logic        lo_ovf;
    logic        lo_udf;
    logic [2:0]  psc;
    logic [2:0]  clr_sel;
    logic [2:0]  clr_m1;
    logic [1:0]  pwm;
    logic [15:0] nxt;

    assign pin_raw = {capture_compare_pin_d_i[c], capture_compare_pin_c_i[c],
                      capture_compare_pin_b_i[c], capture_compare_pin_a_i[c]};

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        s1_q <= 4'h0;
        s2_q <= 4'h0;
        s3_q <= 4'h0;
      end
      else
      begin
        s1_q <= pin_raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    assign run     = ctrl_q[c][CTRL_RUN];
    assign psc     = ctrl_q[c][CTRL_PSC +: 3];
    assign clr_sel = ctrl_q[c][CTRL_CLR +: 3];
    assign clr_m1  = clr_sel - 3'h1;
    assign per_ok  = (clr_sel != CLR_NONE) & (clr_sel <= CLR_LAST);
    assign pwm     = mode_q[c][MODE_PWM +: 2];
    assign ph      = PHASE_CH[c] & mode_q[c][MODE_PHASE];
    assign casc    = UPPER_CH[c] & ~ph & (psc == PSC_CASCADE);

    if (PHASE_CH[c])
    begin : g_ph
      mpt_quad u_quad (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .phase_a  (SRC_CD[c] ? ext_clock_in_c : ext_clock_in_a),
        .phase_b  (SRC_CD[c] ? ext_clock_in_d : ext_clock_in_b),
        .sub_mode (mode_q[c][MODE_SUB +: 2]),
        .count_up (q_up),
        .count_dn (q_dn)
      );
    end
    else
    begin : g_noph
      assign q_up = 1'b0;
      assign q_dn = 1'b0;
    end

    if (UPPER_CH[c])
    begin : g_up
      assign lo_ovf = ovf_w[c+1];
      assign lo_udf = udf_w[c+1];
    end
    else
    begin : g_solo
      assign lo_ovf = 1'b0;
      assign lo_udf = 1'b0;
    end

    assign inc      = run & (ph ? q_up : (casc ? lo_ovf : tick_of(psc, div_q)));
    assign dec      = run & (ph ? q_dn : (casc & lo_udf));
    assign ovf_w[c] = inc & (cnt_q[c] == CNT_MAX);
    assign udf_w[c] = dec & (cnt_q[c] == CNT_RST);
    assign nxt      = inc ? cnt_q[c] + 16'h0001 : (dec ? cnt_q[c] - 16'h0001 : cnt_q[c]);
    assign ev       = hit | capt;
    assign clr      = per_ok & ev[clr_m1[1:0]];

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        cnt_q[c] <= CNT_RST;
        dir_q[c] <= DIR_RST;
      end
      else
      begin
        if (wr_hit(CI, IDX_CNT))
          cnt_q[c] <= hwdata[15:0];
        else if (clr)
          cnt_q[c] <= CNT_RST;
        else
          cnt_q[c] <= nxt;
        if (inc)
          dir_q[c] <= 1'b1;
        else if (dec)
          dir_q[c] <= 1'b0;
      end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ctrl_q[c]  <= '0;
        mode_q[c]  <= '0;
        io_q[c]    <= '0;
        ier_q[c]   <= '0;
        flag_q[c]  <= '0;
        irq_req[c] <= 1'b0;
      end
      else
      begin
        if (wr_hit(CI, IDX_CTRL))
          ctrl_q[c] <= hwdata[CTRL_W-1:0];
        if (wr_hit(CI, IDX_MODE))
          mode_q[c] <= hwdata[MODE_W-1:0];
        if (wr_hit(CI, IDX_IO))
          io_q[c] <= hwdata[15:0];
        if (wr_hit(CI, IDX_IER))
          ier_q[c] <= hwdata[FLAG_W-1:0];
        flag_q[c]  <= {udf_w[c], ovf_w[c], ev} | (flag_q[c] & ~(wr_hit(CI, IDX_STAT) ?
                      ~hwdata[FLAG_W-1:0] : 6'h00));
        irq_req[c] <= |(flag_q[c] & ier_q[c]);
      end
    end

    // ----------------------------------------------------------
    // general registers
    // ----------------------------------------------------------
    for (genvar r = 0; r < NGR; r++)
    begin : g_gr
      localparam bit LIVE = (r < 2) || CD_CH[c];
      logic [3:0] ion;
      logic       rise;
      logic       fall;
      logic       bufd;

      assign ion     = io_q[c][4*r +: 4];
      assign rise    = s2_q[r] & ~s3_q[r];
      assign fall    = ~s2_q[r] & s3_q[r];
      assign hit[r]  = LIVE & ~ion[IO_CAP] & (inc | dec) & (nxt == gr_q[c][r]);
      assign capt[r] = LIVE & ion[IO_CAP] & ((ion[1:0] == EDGE_RISE) ? rise :
                       ((ion[1:0] == EDGE_FALL) ? fall : (rise | fall)));

      if (r < 2)
      begin : g_lo
        assign bufd = CD_CH[c] & mode_q[c][MODE_BUFA + r];
        always_ff @(posedge hclk or negedge hresetn)
        begin
          if (!hresetn)
            gr_q[c][r] <= GR_RST;
          else if (capt[r])
            gr_q[c][r] <= cnt_q[c];
          else if (hit[r] & bufd)
            gr_q[c][r] <= gr_q[c][r+2];
          else if (wr_hit(CI, IDX_GRA + 4'(r)))
            gr_q[c][r] <= hwdata[15:0];
        end
      end
      else
      begin : g_hi
        assign bufd = CD_CH[c] & mode_q[c][MODE_BUFA + r - 2];
        always_ff @(posedge hclk or negedge hresetn)
        begin
          if (!hresetn)
            gr_q[c][r] <= GR_RST;
          else if (capt[r-2] & bufd)
            gr_q[c][r] <= gr_q[c][r-2];
          else if (capt[r] & ~bufd)
            gr_q[c][r] <= cnt_q[c];
          else if (wr_hit(CI, IDX_GRA + 4'(r)))
            gr_q[c][r] <= hwdata[15:0];
        end
      end
    end

    // ----------------------------------------------------------
    // waveform pins
    // ----------------------------------------------------------
    for (genvar p = 0; p < NGR; p++)
    begin : g_pin
      localparam bit LIVE = (p < 2) || CD_CH[c];
      localparam int PR   = (p % 2 == 0) ? p + 1 : p - 1;
      logic [1:0] act;
      logic       init;
      logic       lvl_d;
      logic       oe_d;

      assign act  = io_q[c][4*p +: 2];
      assign init = io_q[c][4*p + IO_INIT];

      always_comb
      begin
        lvl_d = pin_q[c][p];
        oe_d  = LIVE & ~io_q[c][4*p + IO_CAP] & (act != ACT_HOLD);
        if (pwm == PWM_M1)
        begin
          oe_d = LIVE & (p % 2 == 0);
          if (gr_q[c][p] == gr_q[c][PR])
            lvl_d = pin_q[c][p];
          else if (hit[p])
            lvl_d = apply_act(pin_q[c][p], act);
          else if (hit[PR])
            lvl_d = apply_act(pin_q[c][p], io_q[c][4*PR +: 2]);
        end
        else if (pwm == PWM_M2)
        begin
          oe_d = LIVE & ~(per_ok & (clr_m1[1:0] == 2'(p)));
          if (clr)
            lvl_d = init;
          else if (hit[p] & ~(per_ok & (gr_q[c][p] == gr_q[c][clr_m1[1:0]])))
            lvl_d = apply_act(pin_q[c][p], act);
        end
        else if (hit[p])
          lvl_d = apply_act(pin_q[c][p], act);
        if (!run)
          lvl_d = (pwm == PWM_M1) ? io_q[c][4*(p - p % 2) + IO_INIT] : init;
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          pin_q[c][p] <= 1'b0;
          oe_q[c][p]  <= 1'b0;
        end
        else
        begin
          pin_q[c][p] <= lvl_d;
          oe_q[c][p]  <= oe_d;
        end
      end
    end

    assign capture_compare_pin_a_o[c]  = pin_q[c][0];
    assign capture_compare_pin_b_o[c]  = pin_q[c][1];
    assign capture_compare_pin_c_o[c]  = pin_q[c][2];
    assign capture_compare_pin_d_o[c]  = pin_q[c][3];
    assign capture_compare_pin_a_oe[c] = oe_q[c][0];
    assign capture_compare_pin_b_oe[c] = oe_q[c][1];
    assign capture_compare_pin_c_oe[c] = oe_q[c][2];
    assign capture_compare_pin_d_oe[c] = oe_q[c][3];
  end
endmodule : mpt_top

/* sim/mpt_encoder_model.sv */
/*
  two-phase encoder model driving the four external clock inputs.
  assumes the bench calls step from its main sequence only.
*/
`timescale 1ns/1ps
module mpt_encoder_model (
  input  wire logic hclk,
  output logic      ext_clock_in_a,
  output logic      ext_clock_in_b,
  output logic      ext_clock_in_c,
  output logic      ext_clock_in_d
);
  logic [1:0] ab_q = 2'h0;
  logic [1:0] cd_q = 2'h0;
  // gray sequence 00,10,11,01: a leads b when counting up
  assign ext_clock_in_a = ab_q inside {2'h1, 2'h2};
  assign ext_clock_in_b = ab_q[1];
  assign ext_clock_in_c = cd_q inside {2'h1, 2'h2};
  assign ext_clock_in_d = cd_q[1];
  task automatic step(input logic cd, input logic up, input int n);
    repeat (n)
    begin
      repeat (8) @(posedge hclk);
      if (cd)
        cd_q <= up ? cd_q + 2'h1 : cd_q - 2'h1;
      else
        ab_q <= up ? ab_q + 2'h1 : ab_q - 2'h1;
    end
    repeat (8) @(posedge hclk);
  endtask : step
endmodule : mpt_encoder_model

/* sim/mpt_top_assertions.sv */
/*
  bus-side checks of the pulse timer unit.
  assumes it is bound to mpt_top and sees only its ports.
*/
`timescale 1ns/1ps
module mpt_top_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  wire rd  = hsel & hready & htrans[1] & ~hwrite;
  wire unm = haddr[31:9] != 23'h0 || haddr[8:6] > 3'h5;
  wire hix = haddr[5:2] > 4'h9 || (haddr[5:2] > 4'h7 && haddr[8:6] != 3'h0
             && haddr[8:6] != 3'h3);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_rdata_idle: assert property (!rd |=> hrdata == 32'h0) else $error("hrdata not idle");
  chk_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper half set");
  chk_unmapped_zero: assert property (rd && unm |=> hrdata == 32'h0) else $error("unmapped");
  chk_index_zero: assert property (rd && hix |=> hrdata == 32'h0) else $error("bad index");
  chk_stat_width: assert property (rd && haddr[5:2] == 4'h4 |=> hrdata[15:7] == 9'h0)
    else $error("status width");
  chk_mode_width: assert property (rd && haddr[5:2] == 4'h1 |=> hrdata[15:7] == 9'h0)
    else $error("mode width");
endmodule : mpt_top_assertions
bind mpt_top mpt_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

/* sim/multichannel_pwm_phase_timer_tb.sv */
/*
  testbench of the pulse timer unit: bus tasks, counting, phase, cascade, pwm.
  assumes mpt_top, the encoder model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module multichannel_pwm_phase_timer_tb
  import mpt_pkg::*;
();
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic           hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]     htrans = 2'h0;
  logic           hreadyout, hresp, ea, eb, ec, ed;
  logic [NCH-1:0] pa_o, pb_o, oa, ob, oc, od, irq_req, cap_a = 6'h00;
  int             num_errors = 0, samples_checked = 0, cyc = 0;
  mpt_encoder_model enc (.hclk(hclk), .ext_clock_in_a(ea), .ext_clock_in_b(eb),
    .ext_clock_in_c(ec), .ext_clock_in_d(ed));
  mpt_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clock_in_a(ea),
    .ext_clock_in_b(eb), .ext_clock_in_c(ec), .ext_clock_in_d(ed),
    .capture_compare_pin_a_i(cap_a), .capture_compare_pin_b_i(6'h0),
    .capture_compare_pin_c_i(6'h0), .capture_compare_pin_d_i(6'h0),
    .capture_compare_pin_a_o(pa_o), .capture_compare_pin_b_o(pb_o),
    .capture_compare_pin_c_o(), .capture_compare_pin_d_o(),
    .capture_compare_pin_a_oe(oa), .capture_compare_pin_b_oe(ob),
    .capture_compare_pin_c_oe(oc), .capture_compare_pin_d_oe(od), .irq_req(irq_req));
  always #2 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      close_out();
    end
  end
  function automatic logic [31:0] ra(input int c, input logic [3:0] i);
    return {23'h0, 3'(c), i, 2'h0};
  endfunction : ra
  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rc
  task automatic hi(input logic sel, input logic [31:0] e);
    logic [31:0] n;
    n = 32'h0;
    repeat (sel ? 90 : 70)
    begin
      @(posedge hclk);
      n += {31'h0, sel ? pb_o[3] : pa_o[0]};
    end
    chk(n, e);
  endtask : hi
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rc(ra(0, IDX_GRA), ALL, 32'hFFFF);
    rc(ra(1, IDX_STAT), ALL, 32'h40);
    rc(32'h200, ALL, 32'h0);
    rc(ra(6, IDX_CTRL), ALL, 32'h0);
    rc(ra(1, 4'h8), ALL, 32'h0);
    wr(ra(3, IDX_CNT), 32'hFFF0);
    wr(ra(3, IDX_IER), 32'h10);
    wr(ra(3, IDX_CTRL), 32'h1);
    repeat (30) @(posedge hclk);
    rc(ra(3, IDX_STAT), 32'h10, 32'h10);
    chk({31'h0, irq_req[3]}, 32'h1);
    wr(ra(3, IDX_CTRL), 32'h0);
    wr(ra(3, IDX_STAT), 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq_req[3]}, 32'h0);
    wr(ra(2, IDX_MODE), 32'h4);
    wr(ra(2, IDX_CTRL), 32'h1);
    wr(ra(1, IDX_MODE), 32'h4);
    wr(ra(1, IDX_CTRL), 32'hF);
    enc.step(1'b0, 1'b1, 4);
    rc(ra(1, IDX_CNT), ALL, 32'h4);
    rc(ra(2, IDX_CNT), ALL, 32'h0);
    enc.step(1'b0, 1'b0, 8);
    rc(ra(1, IDX_CNT), ALL, 32'hFFFC);
    rc(ra(1, IDX_STAT), 32'h60, 32'h20);
    wr(ra(1, IDX_MODE), 32'h0);
    enc.step(1'b1, 1'b0, 1);
    rc(ra(2, IDX_CNT), ALL, 32'hFFFF);
    rc(ra(1, IDX_CNT), ALL, 32'hFFFB);
    enc.step(1'b1, 1'b1, 1);
    rc(ra(1, IDX_CNT), ALL, 32'hFFFC);
    wr(ra(1, IDX_IO), 32'h8);
    wr(ra(2, IDX_IO), 32'h8);
    wr(ra(0, IDX_CNT), 32'h12);
    wr(ra(0, IDX_IO), 32'hA);
    wr(ra(0, IDX_MODE), 32'h20);
    cap_a <= 6'h07;
    repeat (4) @(posedge hclk);
    wr(ra(0, IDX_CNT), 32'h0);
    cap_a <= 6'h00;
    repeat (4) @(posedge hclk);
    rc(ra(1, IDX_GRA), ALL, 32'hFFFC);
    rc(ra(2, IDX_GRA), ALL, 32'h0);
    rc(ra(0, IDX_GRA), ALL, 32'h0);
    rc(ra(0, 4'h8), ALL, 32'h12);
    wr(ra(0, IDX_GRA), 32'h3);
    wr(ra(0, IDX_GRB), 32'h7);
    wr(ra(0, 4'h8), 32'h5);
    wr(ra(0, IDX_IO), 32'h16);
    wr(ra(0, IDX_MODE), 32'h21);
    rc(ra(0, IDX_MODE), ALL, 32'h21);
    chk({31'h0, pa_o[0]}, 32'h1);
    wr(ra(0, IDX_CTRL), 32'h81);
    repeat (20) @(posedge hclk);
    rc(ra(0, IDX_GRA), ALL, 32'h5);
    hi(1'b0, 32'h14);
    chk({28'h0, oa[0], ob[0], oc[0], od[0]}, 32'hA);
    wr(ra(3, IDX_CNT), 32'h0);
    wr(ra(3, IDX_GRA), 32'h9);
    wr(ra(3, IDX_GRB), 32'h4);
    wr(ra(3, IDX_IO), 32'h23);
    wr(ra(3, IDX_MODE), 32'h2);
    wr(ra(3, IDX_CTRL), 32'h41);
    repeat (20) @(posedge hclk);
    hi(1'b1, 32'h32);
    chk({28'h0, oa[3], ob[3], oc[3], od[3]}, 32'h7);
    close_out();
  end
endmodule : multichannel_pwm_phase_timer_tb
